//--- rtl/eepm_fifo.sv
// byte fifo in front of the record programming path
`timescale 1ns/100ps
module eepm_fifo #(
  parameter int WIDTH = 8, // word width
  parameter int DEPTH = 32 // number of words
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // word to store
  input wire logic in_valid, // source offers a word
  output logic in_ready, // room for a word
  output logic [WIDTH-1:0] out_data, // oldest word
  output logic out_valid, // a word is waiting
  input wire logic out_ready // sink takes the word
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW-1:0] wr_ptr; // next write slot
  logic [AW-1:0] rd_ptr; // next read slot
  logic [AW:0] count; // words held
  wire push = in_valid && in_ready; // word accepted
  wire pop = out_valid && out_ready; // word removed
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop); // occupancy after this edge
  assign out_data = mem[rd_ptr];
  assign out_valid = (count != '0);
  // occupancy and registered ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
  // pointer advance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end
  // word storage, one generate entry per word
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (push && (wr_ptr == AW'(i))) begin
        mem[i] <= in_data;
      end
    end
  end
endmodule : eepm_fifo

//--- rtl/eepm_pkg.sv
// shared constants and types of the emulated eeprom page manager
package eepm_pkg;
  // ----------------------------------------------------------------
  // page layout
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES = 512; // smallest erasable unit
  localparam logic [15:0] CTRL_BYTES = 16'h0009; // control block at page start
  localparam logic [15:0] DATA_BYTES = 16'h01F7; // 503 bytes left for records
  localparam logic [15:0] CTRL_LEN_OFS = 16'h0000; // control byte holding record length
  localparam logic [15:0] CTRL_MAP_OFS = 16'h0001; // first of eight slot map bytes
  localparam int MAX_SLOTS = 64; // one map bit per slot
  localparam logic [6:0] MAX_SLOTS_W = 7'h40; // same, at slot counter width
  localparam logic [7:0] BLANK_BYTE = 8'hFF; // erased flash byte
  localparam logic [7:0] LEN_MIN = 8'h07; // shortest record
  localparam logic [7:0] LEN_MAX = 8'h0F; // longest record
  // ----------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------
  localparam int FIFO_WIDTH = 8; // record bytes
  localparam int FIFO_DEPTH = 32; // record byte buffer depth
  // ----------------------------------------------------------------
  // flash commands and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EEPM_CMD_READ = 2'b00, // read one byte
    EEPM_CMD_PROG = 2'b01, // program one byte
    EEPM_CMD_ERASE = 2'b10 // erase the whole page
  } eepm_cmd_t;
  typedef enum logic [3:0] {
    EEPM_IDLE = 4'b0000, // waiting for a request
    EEPM_CRD = 4'b0001, // reading the control block
    EEPM_DECIDE = 4'b0010, // choose slot or ignore
    EEPM_ERASE = 4'b0011, // page erase
    EEPM_PLEN = 4'b0100, // program record length byte
    EEPM_PDATA = 4'b0101, // program record bytes
    EEPM_PMAP = 4'b0110, // mark slot used
    EEPM_FDATA = 4'b0111, // read record bytes out
    EEPM_DRAIN = 4'b1000, // discard bytes of an ignored store
    EEPM_DONE = 4'b1001 // report completion
  } eepm_state_t;
endpackage : eepm_pkg

//--- rtl/eepm_top.sv
// emulated eeprom page manager: slot allocation over one flash page
// Function
// R1 - requester gives record length 7 to 15
// R2 - requester gives page start address
// R3 - requester keeps one length per page
// R4 - erase always clears whole 512-byte page
// R5 - store programs next unused slot only
// R6 - full page erased, storing restarts
// R7 - 9-byte hidden control block, 503 data
// R8 - slot capacity is data bytes over length; the code caps it at 64 slots, one per map bit
// R9 - store with mismatched length is ignored
// R10 - fetch returns most recently stored record
// R11 - fetch with mismatched length is ignored
// R12 - no alignment or length checking done
// R13 - parameters: speed, length, address high, low
// R14 - request held until done, one at once
`timescale 1ns/100ps
module eepm_top #(
  parameter int FIFO_DEPTH = eepm_pkg::FIFO_DEPTH // record byte buffer depth
) (
  input wire logic clk, // system bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic store_req, // emulated_store request level
  input wire logic fetch_req, // emulated_fetch request level
  input wire logic [7:0] bus_speed_byte, // bus speed parameter
  input wire logic [7:0] record_length, // record length in bytes
  input wire logic [7:0] page_addr_high, // page address high byte
  input wire logic [7:0] page_addr_low, // page address low byte
  input wire logic [7:0] in_data, // record byte to store
  input wire logic in_valid, // record byte offered
  output logic in_ready, // record buffer has room
  output logic [7:0] out_data, // fetched record byte
  output logic out_valid, // fetched byte pulse
  output logic busy, // operation in progress
  output logic done, // completion pulse
  output logic ignored, // completion was an ignored request
  output logic flash_req, // flash command held until ack
  output eepm_pkg::eepm_cmd_t flash_cmd, // flash command
  output logic [15:0] flash_addr, // flash byte address
  output logic [7:0] flash_wdata, // byte to program
  output logic [7:0] flash_speed, // bus speed for flash timing
  input wire logic flash_ack, // command finished pulse
  input wire logic [7:0] flash_rdata // read byte, valid with ack
);
  import eepm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eepm_state_t state; // sequencer state
  logic is_store; // current request is a store
  logic [7:0] rec_len; // latched record length
  logic [15:0] page_base; // latched page address
  logic [7:0] ctrl_len; // length byte read from page
  logic [63:0] slot_map; // slot map, 0 means used
  logic [6:0] slot; // slot being written or read
  logic [7:0] idx; // byte counter inside a phase
  logic fail; // request being ignored
  logic fifo_pop; // take a record byte
  wire [7:0] fifo_data; // oldest record byte
  wire fifo_valid; // record byte waiting

  // ----------------------------------------------------------------
  // record byte buffer
  // ----------------------------------------------------------------
  eepm_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------------------------------
  // slot arithmetic
  // ----------------------------------------------------------------
  // first blank slot, slots fill strictly in order
  function automatic logic [6:0] first_blank(input logic [63:0] map);
    logic [6:0] n;
    logic hit;
    n = MAX_SLOTS_W;
    hit = 1'b0;
    for (int i = 0; i < MAX_SLOTS; i++) begin
      if (map[i] && !hit) begin
        n = 7'(i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction : first_blank

  wire [15:0] len_w = {8'h00, rec_len}; // length at address width
  wire [15:0] raw_cap = (len_w == 16'h0000) ? 16'h0000 : DATA_BYTES / len_w; // R8
  wire [6:0] slot_cap = (raw_cap > 16'(MAX_SLOTS)) ? MAX_SLOTS_W : raw_cap[6:0]; // R8
  wire [6:0] next_slot = first_blank(slot_map); // next unused slot
  wire page_full = (next_slot >= slot_cap); // no blank slot left
  wire len_blank = (ctrl_len == BLANK_BYTE); // page never written
  wire len_match = (ctrl_len == rec_len); // same record length
  wire [15:0] slot_ofs = 16'({9'h000, slot} * len_w); // slot start inside data area
  wire [15:0] data_addr = page_base + CTRL_BYTES + slot_ofs + {8'h00, idx}; // R7
  wire [15:0] ctrl_addr = page_base + CTRL_LEN_OFS + {8'h00, idx}; // control block byte
  wire [15:0] map_addr = page_base + CTRL_MAP_OFS + {13'h0000, slot[5:3]}; // map byte of slot
  wire [7:0] map_byte = slot_map[{slot[5:3], 3'b000} +: 8]; // current map byte
  wire [7:0] map_clear = map_byte & ~(8'h01 << slot[2:0]); // used bit programmed low
  wire last_byte = (idx == rec_len - 8'h01); // final byte of a record
  wire new_req = store_req || fetch_req; // any request level
  wire issue = !flash_req; // no command outstanding
  wire pdata_go = issue && fifo_valid; // byte ready to program

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one flash command per step; each step waits for the ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EEPM_IDLE;
      is_store <= 1'b0;
      rec_len <= 8'h00;
      page_base <= 16'h0000;
      flash_speed <= 8'h00;
      ctrl_len <= BLANK_BYTE;
      slot_map <= '1;
      slot <= 7'h00;
      idx <= 8'h00;
      fail <= 1'b0;
    end else begin
      case (state)
        // accept a request and latch its parameter block
        EEPM_IDLE: begin
          if (new_req) begin // R14
            is_store <= store_req;
            flash_speed <= bus_speed_byte; // R13
            rec_len <= record_length; // R13
            page_base <= {page_addr_high, page_addr_low}; // R13
            idx <= 8'h00;
            fail <= 1'b0;
            state <= EEPM_CRD;
          end
        end
        // read length byte and eight map bytes
        EEPM_CRD: begin
          if (flash_ack) begin
            if (idx == 8'h00) begin
              ctrl_len <= flash_rdata;
            end else begin
              slot_map[{idx[2:0] - 3'h1, 3'b000} +: 8] <= flash_rdata;
            end
            idx <= idx + 8'h01;
            if (idx == CTRL_BYTES[7:0] - 8'h01) begin
              state <= EEPM_DECIDE;
            end
          end
        end
        // pick the slot, erase, or ignore
        EEPM_DECIDE: begin
          idx <= 8'h00;
          if (is_store) begin
            if (!len_blank && !len_match) begin // R9
              fail <= 1'b1;
              state <= EEPM_DRAIN;
            end else if (len_blank) begin
              slot <= 7'h00;
              state <= EEPM_PLEN;
            end else if (page_full) begin // R6
              state <= EEPM_ERASE;
            end else begin
              slot <= next_slot; // R5
              state <= EEPM_PDATA;
            end
          end else begin
            if (!len_match || (next_slot == 7'h00)) begin // R11
              fail <= 1'b1;
              state <= EEPM_DONE;
            end else begin
              slot <= next_slot - 7'h01; // R10
              state <= EEPM_FDATA;
            end
          end
        end
        // whole page back to blank
        EEPM_ERASE: begin
          if (flash_ack) begin // R4
            slot_map <= '1;
            ctrl_len <= BLANK_BYTE;
            slot <= 7'h00; // R6
            state <= EEPM_PLEN;
          end
        end
        // record length into the control block
        EEPM_PLEN: begin
          if (flash_ack) begin
            ctrl_len <= rec_len;
            state <= EEPM_PDATA;
          end
        end
        // record bytes into the chosen slot
        EEPM_PDATA: begin
          if (flash_ack) begin // R5
            idx <= idx + 8'h01;
            if (last_byte) begin
              state <= EEPM_PMAP;
            end
          end
        end
        // mark the slot used
        EEPM_PMAP: begin
          if (flash_ack) begin
            slot_map[slot[5:0]] <= 1'b0;
            state <= EEPM_DONE;
          end
        end
        // newest record out to the requester
        EEPM_FDATA: begin
          if (flash_ack) begin // R10
            idx <= idx + 8'h01;
            if (last_byte) begin
              state <= EEPM_DONE;
            end
          end
        end
        // discard the record bytes of an ignored store
        EEPM_DRAIN: begin
          if (fifo_valid) begin // R9
            idx <= idx + 8'h01;
            if (last_byte) begin
              state <= EEPM_DONE;
            end
          end
        end
        // wait for the request to drop
        EEPM_DONE: begin
          if (!new_req) begin // R14
            state <= EEPM_IDLE;
          end
        end
        default: begin
          state <= EEPM_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flash command port
  // ----------------------------------------------------------------
  wire want_cmd = (state == EEPM_CRD) || (state == EEPM_ERASE) || (state == EEPM_PLEN) ||
                  (state == EEPM_PMAP) || (state == EEPM_FDATA); // states issuing without data wait
  // command raised in a step, held until acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_req <= 1'b0;
      flash_cmd <= EEPM_CMD_READ;
      flash_addr <= 16'h0000;
      flash_wdata <= BLANK_BYTE;
    end else if (flash_ack) begin
      flash_req <= 1'b0;
    end else if (issue && want_cmd) begin
      flash_req <= 1'b1;
      case (state)
        EEPM_CRD: begin
          flash_cmd <= EEPM_CMD_READ; // R7
          flash_addr <= ctrl_addr;
        end
        EEPM_ERASE: begin
          flash_cmd <= EEPM_CMD_ERASE; // R4
          flash_addr <= page_base;
        end
        EEPM_PLEN: begin
          flash_cmd <= EEPM_CMD_PROG;
          flash_addr <= page_base + CTRL_LEN_OFS;
          flash_wdata <= rec_len;
        end
        EEPM_PMAP: begin
          flash_cmd <= EEPM_CMD_PROG;
          flash_addr <= map_addr;
          flash_wdata <= map_clear;
        end
        default: begin
          flash_cmd <= EEPM_CMD_READ; // R10
          flash_addr <= data_addr;
        end
      endcase
    end else if ((state == EEPM_PDATA) && pdata_go) begin
      flash_req <= 1'b1;
      flash_cmd <= EEPM_CMD_PROG; // R5
      flash_addr <= data_addr;
      flash_wdata <= fifo_data;
    end
  end

  // record byte taken as its program command goes out, or dropped while draining
  assign fifo_pop = ((state == EEPM_PDATA) && pdata_go && !flash_ack) || (state == EEPM_DRAIN);

  // ----------------------------------------------------------------
  // requester outputs
  // ----------------------------------------------------------------
  // entry into the completion state, seen one edge early
  wire next_state_done = ((state == EEPM_DECIDE) && !is_store && (!len_match || (next_slot == 7'h00))) ||
                         ((state == EEPM_PMAP) && flash_ack) ||
                         ((state == EEPM_FDATA) && flash_ack && last_byte) ||
                         ((state == EEPM_DRAIN) && fifo_valid && last_byte);
  wire next_fail = fail || (state == EEPM_DECIDE); // decide only jumps to done when ignoring

  // fetched bytes, busy and completion pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= 8'h00;
      out_valid <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ignored <= 1'b0;
    end else begin
      out_valid <= (state == EEPM_FDATA) && flash_ack; // R10
      if ((state == EEPM_FDATA) && flash_ack) begin
        out_data <= flash_rdata;
      end
      busy <= (state != EEPM_IDLE) || new_req; // R14
      done <= (state != EEPM_DONE) && (next_state_done);
      ignored <= (state != EEPM_DONE) && next_state_done && next_fail;
    end
  end

endmodule : eepm_top

//--- tb/eepm_flash_model.sv
// behavioural flash array answering the page manager
`timescale 1ns/100ps
module eepm_flash_model (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic slow, // stretch every answer
  input wire logic flash_req, // command held until ack
  input wire eepm_pkg::eepm_cmd_t flash_cmd, // command
  input wire logic [15:0] flash_addr, // byte address
  input wire logic [7:0] flash_wdata, // byte to program
  output logic flash_ack, // command finished pulse
  output logic [7:0] flash_rdata // read byte with ack
);
  import eepm_pkg::*;
  logic [7:0] mem [0:65535]; // whole array, erased at start
  int wait_cnt; // cycles spent on this command
  int n_erase; // page erases seen
  int n_prog; // bytes programmed
  initial begin
    n_erase = 0;
    n_prog = 0;
    foreach (mem[i]) mem[i] = BLANK_BYTE;
  end
  // answer one command, then idle; read data toggles every cycle except when answering a read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ack <= 1'b0;
      wait_cnt <= 0;
      flash_rdata <= 8'h00;
    end else begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && !flash_ack && wait_cnt < (slow ? 5 : 1)) begin
        wait_cnt <= wait_cnt + 1;
      end else if (flash_req && !flash_ack) begin
        wait_cnt <= 0;
        flash_ack <= 1'b1;
        case (flash_cmd)
          EEPM_CMD_READ: flash_rdata <= mem[flash_addr];
          EEPM_CMD_PROG: begin
            mem[flash_addr] <= mem[flash_addr] & flash_wdata; // programming only clears bits
            n_prog <= n_prog + 1;
          end
          default: begin
            for (int i = 0; i < PAGE_BYTES; i++) mem[{flash_addr[15:9], 9'h000} + i] <= BLANK_BYTE;
            n_erase <= n_erase + 1;
          end
        endcase
      end
    end
  end
endmodule : eepm_flash_model

//--- tb/eepm_top_sva.sv
// concurrent checks on the ports of the page manager
`timescale 1ns/100ps
module eepm_top_sva #(
  parameter int FIFO_DEPTH = 32 // record byte buffer depth
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic store_req, // store request level
  input wire logic fetch_req, // fetch request level
  input wire logic [7:0] out_data, // fetched byte
  input wire logic out_valid, // fetched byte pulse
  input wire logic busy, // operation in progress
  input wire logic done, // completion pulse
  input wire logic ignored, // ignored completion
  input wire logic flash_req, // flash command pending
  input wire eepm_pkg::eepm_cmd_t flash_cmd, // flash command
  input wire logic [15:0] flash_addr, // flash byte address
  input wire logic flash_ack, // flash answer pulse
  input wire logic [7:0] flash_rdata // flash read byte
);
  import eepm_pkg::*;
  // ----------------------------------------------------------------
  // one clock domain for every check
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_IGNORED_AT_DONE: assert property (ignored |-> done)
    else $error("ignored without done");
  AST_FLASH_HOLD: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_addr) && $stable(flash_cmd))
    else $error("flash command changed before ack");
  AST_FLASH_DROP: assert property (flash_req && flash_ack |=> !flash_req)
    else $error("flash request kept after ack");
  AST_ERASE_WHOLE_PAGE: assert property (flash_req && flash_cmd == EEPM_CMD_ERASE |-> flash_addr[8:0] == 9'h000)
    else $error("erase not at page base");
  AST_IDLE_QUIET: assert property (!busy |-> !flash_req)
    else $error("flash access while idle");
  AST_BUSY_ON_REQ: assert property (store_req || fetch_req |=> busy)
    else $error("busy missing while requested");
  AST_FETCH_BYTE: assert property (out_valid |-> $past(flash_ack) && out_data == $past(flash_rdata))
    else $error("fetched byte not from flash answer");
  AST_FETCH_READ_ONLY: assert property (fetch_req && !store_req && flash_req |-> flash_cmd == EEPM_CMD_READ)
    else $error("fetch altered flash");
endmodule : eepm_top_sva
bind eepm_top eepm_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_sva (.clk(clk), .rst_n(rst_n), .store_req(store_req),
  .fetch_req(fetch_req), .out_data(out_data), .out_valid(out_valid), .busy(busy), .done(done), .ignored(ignored),
  .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_ack(flash_ack),
  .flash_rdata(flash_rdata));

//--- tb/testbench.sv
// self-checking bench of the emulated eeprom page manager
`timescale 1ns/100ps
module testbench;
  import eepm_pkg::*;
  logic clk, rst_n, store_req, fetch_req, in_valid, in_ready, out_valid, busy, done, ignored;
  logic flash_req, flash_ack, slow;
  logic [7:0] bus_speed_byte, record_length, page_addr_high, page_addr_low, in_data, out_data;
  logic [7:0] flash_wdata, flash_speed, flash_rdata;
  logic [15:0] flash_addr;
  eepm_cmd_t flash_cmd;
  int n_fail, comparisons;
  eepm_top i_dut (.clk, .rst_n, .store_req, .fetch_req, .bus_speed_byte, .record_length, .page_addr_high,
    .page_addr_low, .in_data, .in_valid, .in_ready, .out_data, .out_valid, .busy, .done, .ignored, .flash_req,
    .flash_cmd, .flash_addr, .flash_wdata, .flash_speed, .flash_ack, .flash_rdata);
  eepm_flash_model i_flash (.clk, .rst_n, .slow, .flash_req, .flash_cmd, .flash_addr, .flash_wdata, .flash_ack,
    .flash_rdata);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rb(input int k, input int i);
    return 8'(k * 17 + i);
  endfunction : rb
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic timeout();
    n_fail++;
    give_verdict();
  endtask : timeout
  // offer record bytes to the fifo, one per accepting edge
  task automatic push(input int k, input int len);
    int t;
    for (int i = 0; i < len; i++) begin
      in_data = rb(k, i);
      in_valid = 1'b1;
      t = 0;
      while (in_ready !== 1'b1 && t < 200) begin
        @(posedge clk);
        #1;
        t++;
      end
      if (in_ready !== 1'b1) timeout();
      @(posedge clk);
      #1;
    end
    in_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : push
  // hold a request until done, judging fetched bytes and the ignore flag
  task automatic request(input logic st, input logic [7:0] len, input logic [15:0] base, input int k,
    input logic ign);
    int t;
    int nb;
    store_req = st;
    fetch_req = !st;
    record_length = len;
    page_addr_high = base[15:8];
    page_addr_low = base[7:0];
    bus_speed_byte = 8'h14;
    t = 0;
    nb = 0;
    while (done !== 1'b1 && t < 5000) begin
      @(posedge clk);
      #1;
      t++;
      if (out_valid === 1'b1) begin
        check(out_data, rb(k, nb));
        nb++;
      end
    end
    if (done !== 1'b1) timeout();
    check(ignored, 16'(ign));
    check(16'(nb), (st || ign) ? 16'h0000 : 16'(len));
    store_req = 1'b0;
    fetch_req = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : request
  task automatic st(input int k, input logic [7:0] len, input logic [15:0] base, input logic ign);
    push(k, len);
    request(1'b1, len, base, k, ign);
  endtask : st
  task automatic chk_slot(input logic [15:0] base, input logic [7:0] len, input int slot, input int k);
    for (int i = 0; i < len; i++) check(i_flash.mem[base + 16'(9 + slot * len + i)], rb(k, i));
  endtask : chk_slot
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(in_ready, 16'h0001);
    check(busy, 16'h0000);
    check(flash_req, 16'h0000);
    check(flash_wdata, 16'h00FF);
  endtask : t_reset
  task automatic t_store_fetch();
    int p;
    for (int k = 1; k <= 3; k++) st(k, 8'h08, 16'hEE00, 1'b0);
    for (int s = 0; s < 3; s++) chk_slot(16'hEE00, 8'h08, s, s + 1);
    check(i_flash.mem[16'hEE00], 16'h0008);
    check(i_flash.mem[16'hEE01], 16'h00F8);
    check(flash_speed, 16'h0014);
    request(1'b0, 8'h08, 16'hEE00, 3, 1'b0);
    request(1'b0, 8'h09, 16'hEE00, 3, 1'b1);
    p = i_flash.n_prog;
    st(9, 8'h09, 16'hEE00, 1'b1);
    check(16'(i_flash.n_prog), 16'(p));
  endtask : t_store_fetch
  // fill the fifo until it refuses, then drain it with a slow flash
  task automatic t_fifo_full();
    slow = 1'b1;
    for (int k = 4; k < 8; k++) push(k, 8);
    check(in_ready, 16'h0000);
    for (int k = 4; k < 8; k++) request(1'b1, 8'h08, 16'hEE00, k, 1'b0);
    for (int s = 3; s < 7; s++) chk_slot(16'hEE00, 8'h08, s, s + 1);
    check(in_ready, 16'h0001);
    slow = 1'b0;
  endtask : t_fifo_full
  // fill a fresh page to capacity, then one more store forces an erase
  task automatic t_wrap(input logic [15:0] base, input logic [7:0] len, input int cap);
    int e;
    request(1'b0, len, base, 0, 1'b1);
    e = i_flash.n_erase;
    for (int j = 0; j < cap; j++) st(j, len, base, 1'b0);
    check(16'(i_flash.n_erase), 16'(e));
    chk_slot(base, len, cap - 1, cap - 1);
    st(cap, len, base, 1'b0);
    check(16'(i_flash.n_erase), 16'(e + 1));
    chk_slot(base, len, 0, cap);
    check(i_flash.mem[base + 16'h0009 + 16'(len)], 16'h00FF);
    check(i_flash.mem[base + 16'h0001], 16'h00FE);
    request(1'b0, len, base, cap, 1'b0);
  endtask : t_wrap
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    slow = 1'b0;
    store_req = 1'b0;
    fetch_req = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    bus_speed_byte = 8'h00;
    record_length = 8'h00;
    page_addr_high = 8'h00;
    page_addr_low = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_store_fetch();
    t_fifo_full();
    t_wrap(16'hEC00, 8'h0F, 33);
    t_wrap(16'hEA00, 8'h08, 62);
    t_wrap(16'hE800, 8'h07, 64);
    give_verdict();
  end
endmodule : testbench
